// *** rtl/rswc_pkg.sv ***
// Constants, types and register map shared by the reset and wake-up controller.
// Assumes a 125 MHz system clock; every millisecond time below is turned into clock cycles here.
package rswc_pkg;

  // Clock rate in MHz, used to turn times into cycle counts.
  localparam int CLK_MHZ = 125;
  // Reset hold in most oscillator modes, in milliseconds.
  localparam int RST_HOLD_MS = 18;
  // Reset hold and wake delay in the low-frequency crystal mode, in milliseconds.
  localparam int LXT_HOLD_MS = 500;
  // Crystal start-up part of the high-crystal wake delay, in milliseconds.
  localparam int HXT_WAKE_MS = 2;
  // Oscillator settling clocks added to port and comparator wake delays in the RC and high-crystal modes.
  localparam int OSC_SETTLE_CLKS = 32;
  // Wake delay after an ADC completion, in ADC clock periods.
  localparam int ADC_WAKE_TAD = 15;
  // Default length of one ADC clock period in system clocks.
  localparam int ADC_TAD_CLKS = 16;

  // Derived cycle counts.
  localparam logic [31:0] HOLD_CYC = 32'(RST_HOLD_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] LXT_CYC = 32'(LXT_HOLD_MS * 1000 * CLK_MHZ);
  localparam logic [31:0] HXT_WAKE_CYC = 32'(HXT_WAKE_MS * 1000 * CLK_MHZ + OSC_SETTLE_CLKS);
  localparam logic [31:0] RC_WAKE_CYC = 32'(OSC_SETTLE_CLKS);

  // Register byte offsets on the APB.
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_PULL_DN = 8'h04;
  localparam logic [7:0] OFS_OPEN_DR = 8'h08;
  localparam logic [7:0] OFS_PULL_HI = 8'h0C;
  localparam logic [7:0] OFS_WDT_CTRL = 8'h10;
  localparam logic [7:0] OFS_WAKE_CTRL = 8'h14;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_MODE = 8'h20;

  // Field positions.
  localparam int ST_T_BIT = 4;
  localparam int ST_P_BIT = 3;
  localparam int WDT_EN_BIT = 6;
  localparam int WK_PORT_BIT = 1;
  localparam int WK_CMP_BIT = 2;
  localparam int WK_ADC_BIT = 3;

  // Reset values and the bits cleared by a reset event.
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] STATUS_POR_CLR = 8'hE0;
  localparam logic [7:0] IO_CTRL_RST = 8'hFF;
  localparam logic [7:0] WDT_CTRL_CLR = 8'hB0;
  localparam logic [7:0] WAKE_CTRL_CLR = 8'h30;
  localparam logic [7:0] ZERO8 = 8'h00;

  // Oscillator mode codes held in the mode register.
  localparam logic [1:0] OSC_RC = 2'h0;
  localparam logic [1:0] OSC_HXT = 2'h1;
  localparam logic [1:0] OSC_LXT = 2'h2;

  // Program counter values loaded after a reset or a wake-up.
  localparam logic [9:0] VEC_RESET = 10'h000;
  localparam logic [9:0] VEC_PORT = 10'h006;
  localparam logic [9:0] VEC_CMP = 10'h00F;
  localparam logic [9:0] VEC_ADC = 10'h00C;

  // Controller states.
  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP, ST_WAKE} rswc_state_t;

  // Which wake source started the wake delay.
  typedef enum logic [1:0] {WS_PORT, WS_CMP, WS_ADC} rswc_src_t;

  // One-cycle wake events from the port, comparator and ADC logic.
  typedef struct packed {
    logic port_chg;
    logic cmp_chg;
    logic adc_done;
  } rswc_wake_t;

  // Level controls sent to the core and its peripherals.
  typedef struct packed {
    logic core_rst;
    logic osc_run;
    logic timer_run;
    logic io_input;
    logic sleeping;
  } rswc_core_t;

endpackage

// *** rtl/rswc_ctrl.sv ***
// Reset, sleep and wake-up controller with an APB register file.
// Assumes core events arrive on this clock; the reset pin and the watchdog tick are asynchronous.
`timescale 1ns/10ps
module rswc_ctrl import rswc_pkg::*; #(
  parameter logic [31:0] HOLD_CLKS = HOLD_CYC,
  parameter logic [31:0] LXT_CLKS = LXT_CYC,
  parameter logic [31:0] HXT_WAKE_CLKS = HXT_WAKE_CYC,
  parameter int TAD_CLKS = ADC_TAD_CLKS,
  parameter logic [15:0] WDT_LIMIT = 16'h00FF
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic wdt_tick,
  input wire logic sleep_instruction,
  input wire logic watchdog_clear_instruction,
  input wire logic global_irq_en,
  input wire logic adc_busy,
  input wire rswc_wake_t wake_evt,
  output rswc_core_t core_ctl,
  output logic pc_load,
  output logic [9:0] pc_value,
  output logic resume
);

  // Wake delay after an ADC completion, in system clocks.
  localparam logic [31:0] ADC_WAKE_CLKS = 32'(ADC_WAKE_TAD * TAD_CLKS);

  rswc_state_t state_q; // Controller state.
  rswc_src_t src_q; // Source of the pending wake.
  logic [31:0] cnt_q; // Hold and wake delay counter.
  logic [31:0] wake_lim_q; // Length of the pending wake delay.
  logic adc_keep_q; // Sleep entered during a conversion.
  logic [2:0] pin_sync_q; // Reset pin synchroniser chain.
  logic pin_lvl_q; // Filtered reset pin level.
  logic [2:0] tick_sync_q; // Watchdog tick synchroniser chain.
  logic tick_lvl_q; // Filtered watchdog tick level.
  logic [7:0] wdt_pre_q; // Watchdog prescaler.
  logic [15:0] wdt_cnt_q; // Watchdog counter.
  logic [7:0] status_reg, pull_down_ctrl, open_drain_ctrl, pull_high_ctrl;
  logic [7:0] watchdog_ctrl_mask, wake_ctrl_reg, interrupt_flag_reg, interrupt_mask_reg;
  logic [1:0] osc_mode_q; // Oscillator mode.
  logic pc_load_q, resume_q; // Registered core strobes.
  logic [9:0] pc_value_q; // Registered program counter value.

  logic wdt_en, tick_edge, wdt_to, pin_low, rst_evt, sleep_go;
  logic hold_done, wake_done, wake_any;
  logic [31:0] hold_lim;
  logic apb_wr, apb_rd_ok;

  // Watchdog enable, tick edge and timeout.
  assign wdt_en = watchdog_ctrl_mask[WDT_EN_BIT];
  assign tick_edge = (tick_sync_q[2] == tick_sync_q[1]) && (tick_sync_q[1] != tick_lvl_q);
  assign wdt_to = wdt_en && (wdt_cnt_q == WDT_LIMIT);
  // A reset event restarts the hold from any state.
  assign pin_low = !pin_lvl_q;
  assign rst_evt = pin_low || wdt_to;
  assign sleep_go = (state_q == ST_RUN) && sleep_instruction && !rst_evt;
  // Reset hold length depends on the oscillator mode.
  assign hold_lim = (osc_mode_q == OSC_LXT) ? LXT_CLKS : HOLD_CLKS;
  assign hold_done = (cnt_q == hold_lim - 32'h1);
  assign wake_done = (cnt_q == wake_lim_q - 32'h1);
  // Enabled wake events; a running watchdog masks all of them.
  assign wake_any = !wdt_en && ((wake_evt.port_chg && wake_ctrl_reg[WK_PORT_BIT])
    || (wake_evt.cmp_chg && wake_ctrl_reg[WK_CMP_BIT])
    || (wake_evt.adc_done && wake_ctrl_reg[WK_ADC_BIT]));

  // Level controls to the core.
  always_comb begin
    core_ctl.core_rst = (state_q == ST_HOLD);
    core_ctl.osc_run = (state_q != ST_SLEEP) || adc_keep_q;
    core_ctl.timer_run = (state_q == ST_RUN) || ((state_q == ST_SLEEP) && adc_keep_q);
    core_ctl.io_input = (state_q == ST_HOLD);
    core_ctl.sleeping = (state_q == ST_SLEEP) || (state_q == ST_WAKE);
  end
  assign pc_load = pc_load_q;
  assign pc_value = pc_value_q;
  assign resume = resume_q;

  // Reset pin: three flops, a change counts once the last two agree.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_sync_q <= 3'h7;
      pin_lvl_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], reset_pin_n};
      if (pin_sync_q[2] == pin_sync_q[1]) begin
        pin_lvl_q <= pin_sync_q[2];
      end
    end
  end

  // Watchdog tick from the RC oscillator, filtered the same way.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_sync_q <= 3'h0;
      tick_lvl_q <= 1'b0;
    end else begin
      tick_sync_q <= {tick_sync_q[1:0], wdt_tick};
      if (tick_sync_q[2] == tick_sync_q[1]) begin
        tick_lvl_q <= tick_sync_q[2];
      end
    end
  end

  // Watchdog prescaler and counter; cleared by reset, sleep and the clear instruction.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wdt_pre_q <= ZERO8;
      wdt_cnt_q <= 16'h0000;
    end else if (rst_evt || sleep_go || watchdog_clear_instruction) begin
      wdt_pre_q <= ZERO8;
      wdt_cnt_q <= 16'h0000;
    end else if (wdt_en && tick_edge) begin
      // The low three control bits set the prescale ratio as a power of two.
      if (wdt_pre_q == ((8'h02 << watchdog_ctrl_mask[2:0]) - 8'h01)) begin
        wdt_pre_q <= ZERO8;
        wdt_cnt_q <= wdt_cnt_q + 16'h0001;
      end else begin
        wdt_pre_q <= wdt_pre_q + 8'h01;
      end
    end
  end

  // Main sequence: hold, run, sleep and wake delay.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_HOLD;
      cnt_q <= 32'h0;
      src_q <= WS_PORT;
      wake_lim_q <= RC_WAKE_CYC;
      adc_keep_q <= 1'b0;
    end else if (rst_evt) begin
      // Pin or watchdog, awake or asleep, means a full reset hold.
      state_q <= ST_HOLD;
      cnt_q <= 32'h0;
      adc_keep_q <= 1'b0;
    end else begin
      case (state_q)
        ST_HOLD: begin
          if (hold_done) begin
            state_q <= ST_RUN;
            cnt_q <= 32'h0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        ST_RUN: begin
          if (sleep_go) begin
            state_q <= ST_SLEEP;
            adc_keep_q <= adc_busy;
          end
        end
        ST_SLEEP: begin
          if (wake_any) begin
            state_q <= ST_WAKE;
            cnt_q <= 32'h0;
            if (wake_evt.port_chg && wake_ctrl_reg[WK_PORT_BIT]) begin
              src_q <= WS_PORT;
            end else if (wake_evt.cmp_chg && wake_ctrl_reg[WK_CMP_BIT]) begin
              src_q <= WS_CMP;
            end else begin
              src_q <= WS_ADC;
            end
            // Delay by oscillator mode, or fifteen ADC clocks for ADC wake.
            if (!(wake_evt.port_chg && wake_ctrl_reg[WK_PORT_BIT])
                && !(wake_evt.cmp_chg && wake_ctrl_reg[WK_CMP_BIT])) begin
              wake_lim_q <= ADC_WAKE_CLKS;
            end else if (osc_mode_q == OSC_LXT) begin
              wake_lim_q <= LXT_CLKS;
            end else if (osc_mode_q == OSC_HXT) begin
              wake_lim_q <= HXT_WAKE_CLKS;
            end else begin
              wake_lim_q <= RC_WAKE_CYC;
            end
          end
        end
        ST_WAKE: begin
          if (wake_done) begin
            state_q <= ST_RUN;
            cnt_q <= 32'h0;
            adc_keep_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: begin
          state_q <= ST_HOLD;
        end
      endcase
    end
  end

  // Strobes to the core: reset vector, wake vector or plain resume.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pc_load_q <= 1'b0;
      pc_value_q <= VEC_RESET;
      resume_q <= 1'b0;
    end else begin
      pc_load_q <= 1'b0;
      resume_q <= 1'b0;
      if (!rst_evt && (state_q == ST_HOLD) && hold_done) begin
        pc_load_q <= 1'b1;
        pc_value_q <= VEC_RESET;
      end else if (!rst_evt && (state_q == ST_WAKE) && wake_done) begin
        if (global_irq_en) begin
          pc_load_q <= 1'b1;
          pc_value_q <= (src_q == WS_PORT) ? VEC_PORT : (src_q == WS_CMP) ? VEC_CMP : VEC_ADC;
        end else begin
          resume_q <= 1'b1;
        end
      end
    end
  end

  // APB: zero wait states; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  always_comb begin
    apb_rd_ok = 1'b1;
    case (paddr)
      OFS_STATUS: prdata = {24'h0, status_reg};
      OFS_PULL_DN: prdata = {24'h0, pull_down_ctrl};
      OFS_OPEN_DR: prdata = {24'h0, open_drain_ctrl};
      OFS_PULL_HI: prdata = {24'h0, pull_high_ctrl};
      OFS_WDT_CTRL: prdata = {24'h0, watchdog_ctrl_mask};
      OFS_WAKE_CTRL: prdata = {24'h0, wake_ctrl_reg};
      OFS_IRQ_FLAG: prdata = {24'h0, interrupt_flag_reg};
      OFS_IRQ_MASK: prdata = {24'h0, interrupt_mask_reg};
      OFS_MODE: prdata = {28'h0, state_q, osc_mode_q};
      default: begin
        prdata = 32'h0;
        apb_rd_ok = 1'b0;
      end
    endcase
  end
  assign pslverr = psel && penable && !apb_rd_ok;

  // Status register: cause flags follow the reset source, the top bits clear only at power-up.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_reg <= STATUS_RST;
    end else if (wdt_to) begin
      status_reg[ST_T_BIT] <= 1'b0;
      status_reg[ST_P_BIT] <= (state_q == ST_RUN) || (state_q == ST_HOLD);
    end else if (pin_low) begin
      if (state_q == ST_SLEEP || state_q == ST_WAKE) begin
        status_reg[ST_T_BIT] <= 1'b1;
        status_reg[ST_P_BIT] <= 1'b0;
      end
    end else if (watchdog_clear_instruction) begin
      status_reg[ST_T_BIT] <= 1'b1;
      status_reg[ST_P_BIT] <= 1'b1;
    end else if (apb_wr && paddr == OFS_STATUS) begin
      status_reg[7:5] <= pwdata[7:5];
      status_reg[2:0] <= pwdata[2:0];
    end
  end

  // Control registers: reset events load the port defaults, clear flags, mask and the owned control bits and keep the mode; otherwise software writes them.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pull_down_ctrl <= IO_CTRL_RST;
      open_drain_ctrl <= IO_CTRL_RST;
      pull_high_ctrl <= IO_CTRL_RST;
      watchdog_ctrl_mask <= ZERO8;
      wake_ctrl_reg <= ZERO8;
      interrupt_flag_reg <= ZERO8;
      interrupt_mask_reg <= ZERO8;
      osc_mode_q <= OSC_RC;
    end else if (rst_evt) begin
      pull_down_ctrl <= IO_CTRL_RST;
      open_drain_ctrl <= IO_CTRL_RST;
      pull_high_ctrl <= IO_CTRL_RST;
      watchdog_ctrl_mask <= watchdog_ctrl_mask & ~WDT_CTRL_CLR;
      wake_ctrl_reg <= wake_ctrl_reg & ~WAKE_CTRL_CLR;
      interrupt_flag_reg <= ZERO8;
      interrupt_mask_reg <= ZERO8;
    end else if (apb_wr) begin
      case (paddr)
        OFS_PULL_DN: pull_down_ctrl <= pwdata[7:0];
        OFS_OPEN_DR: open_drain_ctrl <= pwdata[7:0];
        OFS_PULL_HI: pull_high_ctrl <= pwdata[7:0];
        OFS_WDT_CTRL: watchdog_ctrl_mask <= pwdata[7:0];
        OFS_WAKE_CTRL: wake_ctrl_reg <= pwdata[7:0];
        OFS_IRQ_FLAG: interrupt_flag_reg <= pwdata[7:0];
        OFS_IRQ_MASK: interrupt_mask_reg <= pwdata[7:0];
        OFS_MODE: osc_mode_q <= pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // A filtered low on the reset pin puts the block into the hold.
  chk_pin_reset: assert property (@(posedge clock) disable iff (!resetn)
    pin_low |=> state_q == ST_HOLD && cnt_q == 32'h0) else $error("pin low did not hold");
  // A watchdog timeout resets and clears the time-out flag.
  chk_wdt_reset: assert property (@(posedge clock) disable iff (!resetn)
    wdt_to |=> state_q == ST_HOLD && !status_reg[ST_T_BIT]) else $error("wdt reset missed");
  // A pin reset during sleep or the wake delay marks the flags as a pin wake.
  chk_pin_wake_flags: assert property (@(posedge clock) disable iff (!resetn)
    pin_low && !wdt_to && (state_q == ST_SLEEP || state_q == ST_WAKE)
    |=> status_reg[ST_T_BIT] && !status_reg[ST_P_BIT]) else $error("pin wake flags wrong");
  // The hold ends only when the count reaches one less than the mode's limit.
  chk_hold_len: assert property (@(posedge clock) disable iff (!resetn)
    state_q == ST_HOLD ##1 state_q == ST_RUN |-> $past(cnt_q) == $past(hold_lim) - 32'h1)
    else $error("hold length wrong");
  // Leaving the hold loads the zero vector.
  chk_reset_vec: assert property (@(posedge clock) disable iff (!resetn)
    $past(state_q) == ST_HOLD && state_q == ST_RUN |-> pc_load_q && pc_value_q == VEC_RESET)
    else $error("reset vector wrong");
  // Oscillator and timers stop in sleep unless a conversion was running.
  chk_sleep_clk: assert property (@(posedge clock) disable iff (!resetn)
    state_q == ST_SLEEP |-> core_ctl.osc_run == adc_keep_q && core_ctl.timer_run == adc_keep_q)
    else $error("sleep clock control wrong");
  // Entering sleep clears the watchdog.
  chk_wdt_sleep: assert property (@(posedge clock) disable iff (!resetn)
    sleep_go |=> wdt_cnt_q == 16'h0000 && wdt_pre_q == ZERO8) else $error("wdt not cleared");
  // Any reset event loads the pull-high and open-drain defaults, clears flags and mask and makes the ports inputs.
  chk_reg_defaults: assert property (@(posedge clock) disable iff (!resetn)
    rst_evt |=> pull_high_ctrl == IO_CTRL_RST && open_drain_ctrl == IO_CTRL_RST
    && interrupt_flag_reg == ZERO8 && interrupt_mask_reg == ZERO8 && core_ctl.io_input)
    else $error("reset defaults wrong");
  // Any reset event clears the watchdog and the control bits that a reset owns.
  chk_wdt_bits_clear: assert property (@(posedge clock) disable iff (!resetn)
    rst_evt |=> wdt_cnt_q == 16'h0000 && wdt_pre_q == ZERO8
    && (watchdog_ctrl_mask & WDT_CTRL_CLR) == ZERO8 && (wake_ctrl_reg & WAKE_CTRL_CLR) == ZERO8)
    else $error("reset clear bits wrong");
  // With the watchdog enabled no wake bit starts a wake delay.
  chk_wake_masked: assert property (@(posedge clock) disable iff (!resetn)
    state_q == ST_SLEEP && wdt_en |=> state_q != ST_WAKE) else $error("wake not masked");
  // Disabled events leave the block asleep.
  chk_wake_ignore: assert property (@(posedge clock) disable iff (!resetn)
    state_q == ST_SLEEP && !wake_any && !rst_evt |=> state_q == ST_SLEEP)
    else $error("left sleep without cause");
  // An ADC wake with no enabled port or comparator event takes the ADC delay.
  chk_adc_delay: assert property (@(posedge clock) disable iff (!resetn)
    state_q == ST_SLEEP && wake_any && !rst_evt
    && !(wake_evt.port_chg && wake_ctrl_reg[WK_PORT_BIT])
    && !(wake_evt.cmp_chg && wake_ctrl_reg[WK_CMP_BIT]) |=> wake_lim_q == ADC_WAKE_CLKS)
    else $error("adc wake delay wrong");
  // End of a wake delay vectors or resumes as the global enable says.
  chk_wake_exit: assert property (@(posedge clock) disable iff (!resetn)
    state_q == ST_WAKE && wake_done && !rst_evt |=> (pc_load_q == $past(global_irq_en))
    && (resume_q == !$past(global_irq_en))) else $error("wake exit wrong");

endmodule

// *** testbench/rswc_core_model.sv ***
// Behavioural model of the processor core that sits beside the controller.
// Assumes it shares the controller clock and only acts while the core runs.
`timescale 1ns/10ps
module rswc_core_model import rswc_pkg::*; (
  input wire logic clock,
  input wire logic sleep_req,
  input wire rswc_core_t core_ctl,
  input wire logic pc_load,
  input wire logic [9:0] pc_value,
  input wire logic resume,
  output logic sleep_instruction = 1'b0,
  output logic [9:0] pc_q = 10'h3FF,
  output logic resumed_q = 1'b0
);
  // The sleep instruction is one pulse, issued only by a running, awake core.
  always_ff @(posedge clock) begin
    sleep_instruction <= sleep_req && !core_ctl.core_rst && !core_ctl.sleeping &&
                         !sleep_instruction;
  end
  // A load replaces the program counter; a resume keeps it and marks the restart.
  always_ff @(posedge clock) begin
    if (pc_load) begin
      pc_q <= pc_value;
      resumed_q <= 1'b0;
    end else if (resume) begin
      resumed_q <= 1'b1;
    end
  end
endmodule

// *** testbench/rswc_ctrl_tb.sv ***
// Self-checking bench for the reset, sleep and wake-up controller.
// Assumes shortened hold and wake parameters so the run stays brief.
`timescale 1ns/10ps
module rswc_ctrl_tb import rswc_pkg::*; ;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pc_load, resume, sleep_instruction, resumed_q;
  logic reset_pin_n = 1'b1;
  logic wdt_tick = 1'b0;
  logic wdc = 1'b0;
  logic global_irq_en = 1'b0;
  logic adc_busy = 1'b0;
  logic sleep_req = 1'b0;
  rswc_wake_t wake_evt = '0;
  rswc_core_t core_ctl;
  logic [9:0] pc_value, pc_q;
  int mismatches = 0;
  int checks = 0;
  int n;

  rswc_ctrl #(.HOLD_CLKS(32'h28), .LXT_CLKS(32'h64), .HXT_WAKE_CLKS(32'h3C), .TAD_CLKS(2),
    .WDT_LIMIT(16'h0003)) dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n), .wdt_tick(wdt_tick),
    .sleep_instruction(sleep_instruction), .watchdog_clear_instruction(wdc),
    .global_irq_en(global_irq_en), .adc_busy(adc_busy), .wake_evt(wake_evt),
    .core_ctl(core_ctl), .pc_load(pc_load), .pc_value(pc_value), .resume(resume));

  rswc_core_model core (.clock(clock), .sleep_req(sleep_req), .core_ctl(core_ctl),
    .pc_load(pc_load), .pc_value(pc_value), .resume(resume),
    .sleep_instruction(sleep_instruction), .pc_q(pc_q), .resumed_q(resumed_q));

  // The 125 MHz system clock.
  initial begin
    forever #4 clock = ~clock;
  end

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; a clock edge passes afterwards so the next never collides.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  // Reads a register and compares the masked value.
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
    chk(32'(e), 32'h0);
  endtask

  // Counts edges until the controller loads the counter or resumes.
  task automatic wait_out(output int c);
    c = 0;
    while (pc_load !== 1'b1 && resume !== 1'b1 && c < 400) begin
      @(posedge clock);
      c++;
    end
  endtask

  // Power-on hold, then register defaults and an unmapped access.
  task automatic por_case();
    logic [31:0] r;
    logic e;
    chk(32'(core_ctl), 32'h1A);
    resetn <= 1'b1;
    wait_out(n);
    chk(32'(n >= 40 && n <= 44), 32'h1);
    chk(32'(pc_value), 32'h0);
    rd(OFS_STATUS, 32'h18);
    rd(OFS_PULL_DN, 32'hFF);
    rd(OFS_OPEN_DR, 32'hFF);
    rd(OFS_PULL_HI, 32'hFF);
    rd(OFS_WDT_CTRL, 32'h0);
    rd(OFS_WAKE_CTRL, 32'h0);
    rd(OFS_IRQ_FLAG, 32'h0);
    rd(OFS_IRQ_MASK, 32'h0);
    apb(1'b0, 8'hFC, 32'h0, r, e);
    chk(32'(e), 32'h1);
  endtask

  // Pin reset in slow crystal mode after dirtying the registers.
  task automatic pin_case();
    wr(OFS_MODE, 32'h2);
    wr(OFS_STATUS, 32'hA0);
    wr(OFS_PULL_DN, 32'h0);
    wr(OFS_WDT_CTRL, 32'hB1);
    wr(OFS_WAKE_CTRL, 32'h3E);
    wr(OFS_IRQ_MASK, 32'hFF);
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge clock);
    chk(32'(core_ctl.core_rst), 32'h1);
    reset_pin_n <= 1'b1;
    wait_out(n);
    chk(32'(n >= 100 && n <= 108), 32'h1);
    rd(OFS_STATUS, 32'hB8, 32'hF8);
    rd(OFS_PULL_DN, 32'hFF);
    rd(OFS_WDT_CTRL, 32'h01);
    rd(OFS_WAKE_CTRL, 32'h0E);
    rd(OFS_IRQ_MASK, 32'h0);
  endtask

  // Prepares sleep, shows a disabled event is ignored, then wakes on the enabled one.
  task automatic wake_case(input logic [1:0] md, input logic [7:0] wk, input rswc_wake_t ev,
      input rswc_wake_t nz, input logic irq, input logic busy, input logic [9:0] vec,
      input int d);
    wr(OFS_MODE, 32'(md));
    wr(OFS_WDT_CTRL, 32'h0);
    wdc <= 1'b1;
    @(posedge clock);
    wdc <= 1'b0;
    global_irq_en <= irq;
    adc_busy <= busy;
    wr(OFS_WAKE_CTRL, 32'(wk));
    sleep_req <= 1'b1;
    do @(posedge clock); while (core_ctl.sleeping !== 1'b1);
    sleep_req <= 1'b0;
    @(posedge clock);
    chk(32'({core_ctl.osc_run, core_ctl.timer_run}), 32'({busy, busy}));
    wake_evt <= nz;
    @(posedge clock);
    wake_evt <= '0;
    repeat (4) @(posedge clock);
    chk(32'(core_ctl.sleeping), 32'h1);
    wake_evt <= ev;
    @(posedge clock);
    wake_evt <= '0;
    wait_out(n);
    chk(32'(n > d && n <= d + 2), 32'h1);
    chk(32'({pc_load, resume}), 32'({irq, !irq}));
    if (irq) begin
      chk(32'(pc_value), 32'(vec));
    end
    @(posedge clock);
    chk(32'(resumed_q), 32'(!irq));
    if (irq) begin
      chk(32'(pc_q), 32'(vec));
    end
    adc_busy <= 1'b0;
  endtask

  // A pin reset during sleep restarts the oscillator and marks the flags.
  task automatic slp_pin_case();
    wr(OFS_WAKE_CTRL, 32'h0);
    sleep_req <= 1'b1;
    do @(posedge clock); while (core_ctl.sleeping !== 1'b1);
    sleep_req <= 1'b0;
    chk(32'(core_ctl.osc_run), 32'h0);
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge clock);
    chk(32'({core_ctl.core_rst, core_ctl.osc_run}), 32'h3);
    reset_pin_n <= 1'b1;
    wait_out(n);
    chk(32'(pc_value), 32'h0);
    rd(OFS_STATUS, 32'h10, 32'h18);
  endtask

  // Watchdog timeout while asleep or awake; the flags record which.
  task automatic wdt_case(input logic slp, input logic [7:0] fl);
    wr(OFS_WAKE_CTRL, 32'h02);
    wr(OFS_WDT_CTRL, 32'h40);
    if (slp) begin
      sleep_req <= 1'b1;
      do @(posedge clock); while (core_ctl.sleeping !== 1'b1);
      sleep_req <= 1'b0;
      wake_evt <= 3'b100;
      @(posedge clock);
      wake_evt <= '0;
      repeat (4) @(posedge clock);
      chk(32'(core_ctl.sleeping), 32'h1);
    end
    for (int i = 0; i < 300 && pc_load !== 1'b1; i++) begin
      @(posedge clock);
      if (i % 4 == 0 && core_ctl.core_rst !== 1'b1) begin
        wdt_tick <= ~wdt_tick;
      end
    end
    chk(32'(pc_value), 32'h0);
    rd(OFS_STATUS, 32'(fl), 32'h18);
    rd(OFS_WDT_CTRL, 32'h40);
    wr(OFS_WDT_CTRL, 32'h0);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge clock);
    por_case();
    pin_case();
    wake_case(OSC_RC, 8'h02, 3'b100, 3'b010, 1'b1, 1'b0, VEC_PORT, 32);
    wake_case(OSC_RC, 8'h04, 3'b010, 3'b001, 1'b0, 1'b0, VEC_CMP, 32);
    wake_case(OSC_RC, 8'h08, 3'b101, 3'b100, 1'b1, 1'b1, VEC_ADC, 30);
    wake_case(OSC_LXT, 8'h04, 3'b010, 3'b100, 1'b1, 1'b0, VEC_CMP, 100);
    wake_case(OSC_HXT, 8'h02, 3'b100, 3'b001, 1'b0, 1'b0, VEC_PORT, 60);
    wr(OFS_MODE, 32'h0);
    slp_pin_case();
    wdt_case(1'b1, 8'h00);
    wdt_case(1'b0, 8'h08);
    end_sim();
  end

  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    end_sim();
  end
endmodule
